/* src/epcmd_pkg.sv */
/*
  Shared constants, types and helpers of the endpoint buffer command port.
  Assumes both ends and the buffer RAM are compiled after this package.
*/
package epcmd_pkg;
  // Endpoint numbering: 0 control OUT, 1 control IN, 2..15 endpoints 1..14
  localparam int EP_CNT = 16;
  localparam int EP_W = 4;
  localparam int DATA_W = 16;
  // N at the bulk/interrupt ceiling; isochronous sizes are not built
  localparam int BUF_BYTES = 32;
  localparam int BUF_WORDS = (BUF_BYTES + 1) / 2; // M
  localparam int PTR_W = 5;
  localparam int MEM_AW = EP_W + 1 + PTR_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  // Word positions inside one buffer
  localparam logic [PTR_W-1:0] LEN_WORD = 5'h00;
  localparam logic [PTR_W-1:0] DMA_FIRST_WORD = 5'h01;
  localparam logic [PTR_W-1:0] LAST_WORD = PTR_W'(BUF_WORDS);
  localparam logic [PTR_W-1:0] XFER_WORDS = PTR_W'(BUF_WORDS + 1); // M+1
  localparam logic [PTR_W-1:0] PTR_STEP = 5'h01;
  // Command codes and groups
  localparam logic [7:0] CMD_RESET = 8'hf6;
  localparam logic [3:0] GRP_WR = 4'h0;
  localparam logic [3:0] GRP_RD = 4'h1;
  localparam logic [3:0] GRP_STALL = 4'h4;
  localparam logic [3:0] GRP_STAT = 4'h5;
  localparam logic [3:0] GRP_UNSTALL = 4'h8;
  localparam logic [3:0] WR_HOLE = 4'h0;
  localparam logic [3:0] RD_HOLE = 4'h1;
  localparam logic [7:0] STAT_PAD = 8'h00;
  localparam logic STAT_RSVD = 1'b0;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10,
    PH_STATUS = 2'b11
  } phase_t;

  // One-hot endpoint mask
  function automatic logic [EP_CNT-1:0] onehot(input logic [EP_W-1:0] ep);
    onehot = '0;
    onehot[ep] = 1'b1;
  endfunction

  // RAM address of one word of one buffer of one endpoint
  function automatic logic [MEM_AW-1:0] buf_addr(input logic [EP_W-1:0] ep, input logic bsel,
                                                 input logic [PTR_W-1:0] word);
    buf_addr = {ep, bsel, word};
  endfunction

  // Index of the last data word for a packet length, clamped to the buffer
  function automatic logic [PTR_W-1:0] last_of_len(input logic [DATA_W-1:0] len);
    logic [DATA_W:0] w;
    w = ({1'b0, len} + 17'h00001) >> 1;
    if (w > {12'h000, LAST_WORD}) begin
      last_of_len = LAST_WORD;
    end else begin
      last_of_len = w[PTR_W-1:0];
    end
  endfunction
endpackage

/* src/cmd_port_if.sv */
/*
  Parallel command/data bus between the processor end and the controller.
  Assumes both ends run on the same SYS_CLK; no clocking block is used.
*/
`timescale 1ns/1ps
`default_nettype none
interface cmd_port_if;
  logic stb; // Access strobe, one cycle
  logic cmd_data_select; // High: command code, low: data
  logic wr; // High: write, low: read
  logic dma; // Access belongs to the DMA stream
  logic [15:0] wdata; // Code or data toward the controller
  logic [3:0] dma_ep; // Endpoint of the DMA stream
  logic transfer_end_signal; // External end of DMA transfer, one cycle
  logic [15:0] rdata; // Answer data
  logic ack; // Answer marker, one cycle
  logic eop; // Last DMA word of the packet, with ack

  modport dev (
    input stb, cmd_data_select, wr, dma, wdata, dma_ep, transfer_end_signal,
    output rdata, ack, eop
  );
  modport host (
    output stb, cmd_data_select, wr, dma, wdata, dma_ep, transfer_end_signal,
    input rdata, ack, eop
  );
endinterface
`default_nettype wire

/* src/ep_buffer_ram.sv */
/*
  Endpoint buffer memory: two buffers of M+1 words per endpoint.
  Assumes port A (processor) and port B (serial engine) never write one word
  in the same cycle; if they do, port A wins.
*/
`timescale 1ns/1ps
`default_nettype none
module ep_buffer_ram import epcmd_pkg::*; (
  input wire logic clk, // System clock
  input wire logic a_we, // Port A write
  input wire logic [MEM_AW-1:0] a_addr, // Port A address
  input wire logic [DATA_W-1:0] a_wdata, // Port A write data
  output logic [DATA_W-1:0] a_rdata, // Port A read, combinational
  input wire logic [MEM_AW-1:0] len_addr, // Length word address
  output logic [DATA_W-1:0] len_rdata, // Length word, combinational
  input wire logic b_we, // Port B write
  input wire logic [MEM_AW-1:0] b_addr, // Port B address
  input wire logic [DATA_W-1:0] b_wdata, // Port B write data
  output logic [DATA_W-1:0] b_rdata // Port B read, registered
);
  logic [DATA_W-1:0] mem [MEM_DEPTH]; // Contents survive resets

  // Combinational reads keep the processor answer to one cycle
  assign a_rdata = mem[a_addr];
  assign len_rdata = mem[len_addr];

  // Writes from both sides, registered engine read
  always_ff @(posedge clk) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    b_rdata <= mem[b_addr];
  end
endmodule
`default_nettype wire

/* src/ep_cmd_device.sv */
/*
  Controller end of the endpoint buffer command port: command decode,
  buffer read/write with pointer, DMA stream, per-endpoint status bytes.
  Assumes the processor end keeps to the access order and the serial engine
  reports packet events as single-cycle pulses on SYS_CLK.
*/
// Summary of operation
// - Reset code reinitialises every register, no data
// - Buffer command returns pointer to buffer start
// - At most M+1 words after buffer command
// - Pointer advances two bytes per access
// - DMA skips length word, starts word one
// - DMA read flags last packet word
// - IN buffer sent only when completely filled
// - External end-of-transfer sends IN buffer anyway
// - Processor never mixes read and write directions
// - Write codes 01-0F, read 10, 12-1F
// - Buffer size N within isochronous/bulk ceilings
// - Length word zero, then two bytes/word
// - Code on low byte, data uses 16
// - Processor stays inside buffers and directions
// - DMA moves to secondary buffer at end
// - Codes 50-5F return one status byte
// - Status read clears endpoint interrupt flag
// - Halt bit set by stall, cleared otherwise
// - Full, setup and buffer-select bits reported
// - Bit 4 shows next data toggle
// - Setup overrun set when a set-up is stored while one is captured, read clears
// - Firmware abandons setup when overrun seen
`timescale 1ns/1ps
`default_nettype none
module ep_cmd_device import epcmd_pkg::*; (
  input wire logic SYS_CLK, // System clock, 50 MHz
  input wire logic RESET, // Synchronous reset, active high
  cmd_port_if.dev BUS, // Processor bus
  input wire logic [EP_CNT-1:0] EP_IS_IN, // Endpoint direction
  input wire logic [EP_CNT-1:0] EP_DOUBLE, // Endpoint double-buffered
  input wire logic ENG_WE, // Engine buffer write
  input wire logic [MEM_AW-1:0] ENG_ADDR, // Engine buffer address
  input wire logic [DATA_W-1:0] ENG_WDATA, // Engine write data
  output logic [DATA_W-1:0] ENG_RDATA, // Engine read data
  input wire logic [EP_W-1:0] ENG_EP, // Endpoint of engine events
  input wire logic ENG_BUF, // Buffer of engine event
  input wire logic ENG_PKT_DONE, // Packet finished on the link
  input wire logic ENG_SETUP_TOKEN, // Set-up token seen
  input wire logic ENG_SETUP_STORED, // Set-up packet written
  input wire logic ENG_TOGGLE, // Flip expected data toggle
  output logic [EP_CNT-1:0] FULL0, // Primary buffer full
  output logic [EP_CNT-1:0] FULL1, // Secondary buffer full
  output logic [EP_CNT-1:0] HALTED, // Endpoint halted
  output logic [EP_CNT-1:0] INT_FLAGS // Interrupt flag register
);
  // Soft reset joins the hard reset, so one path clears everything
  logic soft_rst_r; // Reset code seen last cycle
  logic rst_all; // Combined reset
  assign rst_all = RESET | soft_rst_r;

  // Processor state
  phase_t phase_r, phase_nxt; // Data phase owner
  logic [EP_W-1:0] ep_r, ep_nxt; // Endpoint of last command
  logic [PTR_W-1:0] ptr_r, ptr_nxt; // Word pointer
  logic dma_on_r, dma_on_nxt; // DMA stream in progress
  logic [PTR_W-1:0] dma_ptr_r, dma_ptr_nxt; // DMA word pointer

  // Endpoint status vectors
  logic [EP_CNT-1:0] halt_r, halt_nxt; // Halted
  logic [EP_CNT-1:0] full0_r, full0_nxt; // Primary full
  logic [EP_CNT-1:0] full1_r, full1_nxt; // Secondary full
  logic [EP_CNT-1:0] tog_r, tog_nxt; // Next data toggle
  logic [EP_CNT-1:0] ovr_r, ovr_nxt; // Set-up overrun
  logic [EP_CNT-1:0] setup_r, setup_nxt; // Set-up captured
  logic [EP_CNT-1:0] cpu_side_select_r, cpu_side_select_nxt; // Processor-side buffer
  logic [EP_CNT-1:0] intf_r, intf_nxt; // Interrupt flags

  // Answer registers
  logic [DATA_W-1:0] rdata_r, rdata_nxt; // Read answer
  logic ack_r; // Answer marker
  logic eop_r; // Last DMA word marker

  // Bus decode
  logic cmd_take, dat_take, dma_take; // Access kinds
  logic [7:0] code; // Command code
  logic [3:0] grp, cep; // Code group and endpoint
  logic is_wrcmd, is_rdcmd, is_stat; // Buffer/status codes
  logic stall_cmd, unstall_cmd; // Halt control codes
  assign cmd_take = BUS.stb & BUS.cmd_data_select & ~BUS.dma;
  assign dat_take = BUS.stb & ~BUS.cmd_data_select & ~BUS.dma;
  assign dma_take = BUS.stb & BUS.dma;
  assign code = BUS.wdata[7:0];
  assign grp = code[7:4];
  assign cep = code[3:0];
  assign is_wrcmd = (grp == GRP_WR) && (cep != WR_HOLE);
  assign is_rdcmd = (grp == GRP_RD) && (cep != RD_HOLE);
  assign is_stat = (grp == GRP_STAT);
  assign stall_cmd = cmd_take && (grp == GRP_STALL);
  assign unstall_cmd = cmd_take && (grp == GRP_UNSTALL);

  // Processor data phase
  logic in_range; // Pointer within M+1 words
  logic cpu_buf; // Buffer the processor sees
  logic cpu_we, cpu_rd, stat_rd, cpu_fill; // Data actions
  assign in_range = ptr_r < XFER_WORDS;
  assign cpu_buf = cpu_side_select_r[ep_r];
  assign cpu_we = dat_take && BUS.wr && (phase_r == PH_WRITE) && in_range;
  assign cpu_rd = dat_take && !BUS.wr && (phase_r == PH_READ) && in_range;
  assign stat_rd = dat_take && !BUS.wr && (phase_r == PH_STATUS);
  // A processor data write hands an IN buffer to the engine only when it fills the buffer completely
  assign cpu_fill = cpu_we && (ptr_r == LAST_WORD) && EP_IS_IN[ep_r];

  assign phase_nxt = cmd_take ? (is_wrcmd ? PH_WRITE : is_rdcmd ? PH_READ : is_stat ? PH_STATUS : PH_IDLE)
                   : stat_rd ? PH_IDLE : phase_r;
  assign ep_nxt = cmd_take ? cep : ep_r;
  // Word step of one equals a byte pointer step of two
  assign ptr_nxt = cmd_take ? LEN_WORD
                 : (cpu_we || cpu_rd) ? PTR_W'(ptr_r + PTR_STEP) : ptr_r;

  // DMA stream
  logic dma_buf; // Buffer used by DMA
  logic [PTR_W-1:0] dma_cur; // Word of this DMA access
  logic [DATA_W-1:0] len_q; // Packet length of DMA buffer
  logic dma_at_end, dma_swap, dma_fill, eot_fill, dma_eop, dma_stop; // DMA events
  assign dma_buf = cpu_side_select_r[BUS.dma_ep];
  assign dma_cur = dma_on_r ? dma_ptr_r : DMA_FIRST_WORD;
  assign dma_at_end = dma_cur == LAST_WORD;
  assign dma_swap = dma_take && dma_at_end && EP_DOUBLE[BUS.dma_ep] && !dma_buf;
  assign dma_fill = dma_take && BUS.wr && dma_at_end && EP_IS_IN[BUS.dma_ep];
  // An external end hands over a partly filled IN buffer
  assign eot_fill = BUS.transfer_end_signal && dma_on_r && EP_IS_IN[BUS.dma_ep];
  assign dma_eop = dma_take && !BUS.wr && (dma_cur >= last_of_len(len_q));
  assign dma_stop = BUS.transfer_end_signal || dma_eop || (dma_take && dma_at_end && !dma_swap);
  assign dma_on_nxt = dma_stop ? 1'b0 : (dma_take ? 1'b1 : dma_on_r);
  assign dma_ptr_nxt = dma_swap ? DMA_FIRST_WORD
                     : dma_take ? PTR_W'(dma_cur + PTR_STEP) : dma_ptr_r;

  // Buffer memory shared with the serial engine
  logic [MEM_AW-1:0] a_addr; // Processor-side address
  logic [DATA_W-1:0] a_rdata; // Processor-side word
  assign a_addr = dma_take ? buf_addr(BUS.dma_ep, dma_buf, dma_cur) : buf_addr(ep_r, cpu_buf, ptr_r);

  ep_buffer_ram ep_buffer_ram_inst (
    .clk(SYS_CLK),
    .a_we(cpu_we || (dma_take && BUS.wr)),
    .a_addr(a_addr),
    .a_wdata(BUS.wdata),
    .a_rdata(a_rdata),
    .len_addr(buf_addr(BUS.dma_ep, dma_buf, LEN_WORD)),
    .len_rdata(len_q),
    .b_we(ENG_WE),
    .b_addr(ENG_ADDR),
    .b_wdata(ENG_WDATA),
    .b_rdata(ENG_RDATA)
  );

  // Event masks per endpoint
  logic [EP_CNT-1:0] cpu_mask, dma_mask, eng_mask, stat_mask; // Event sources
  logic [EP_CNT-1:0] stall_mask, unstall_mask, tok_mask, stored_mask, flip_mask, swap_mask;
  logic [EP_CNT-1:0] set0, set1, clr0, clr1; // Full flag edits
  assign cpu_mask = onehot(ep_r) & {EP_CNT{cpu_fill}};
  assign dma_mask = onehot(BUS.dma_ep) & {EP_CNT{dma_fill || eot_fill}};
  assign swap_mask = onehot(BUS.dma_ep) & {EP_CNT{dma_swap}};
  assign eng_mask = onehot(ENG_EP) & {EP_CNT{ENG_PKT_DONE}};
  assign stat_mask = onehot(ep_r) & {EP_CNT{stat_rd}};
  assign stall_mask = onehot(cep) & {EP_CNT{stall_cmd}};
  assign unstall_mask = onehot(cep) & {EP_CNT{unstall_cmd}};
  assign tok_mask = onehot(ENG_EP) & {EP_CNT{ENG_SETUP_TOKEN}};
  assign stored_mask = onehot(ENG_EP) & {EP_CNT{ENG_SETUP_STORED}};
  assign flip_mask = onehot(ENG_EP) & {EP_CNT{ENG_TOGGLE}};

  // Processor fills set full; OUT packets set it, sent IN packets clear it
  assign set0 = (cpu_mask & {EP_CNT{!cpu_buf}}) | (dma_mask & {EP_CNT{!dma_buf}})
              | (eng_mask & ~EP_IS_IN & {EP_CNT{!ENG_BUF}});
  assign set1 = (cpu_mask & {EP_CNT{cpu_buf}}) | (dma_mask & {EP_CNT{dma_buf}})
              | (eng_mask & ~EP_IS_IN & {EP_CNT{ENG_BUF}});
  assign clr0 = eng_mask & EP_IS_IN & {EP_CNT{!ENG_BUF}};
  assign clr1 = eng_mask & EP_IS_IN & {EP_CNT{ENG_BUF}};
  // Sets win over clears on every flag below except the toggle, where the clear beats the flip
  assign full0_nxt = (full0_r & ~clr0) | set0;
  assign full1_nxt = (full1_r & ~clr1) | set1;
  assign halt_nxt = (halt_r & ~(unstall_mask | tok_mask)) | stall_mask;
  // Unstall or set-up token re-initialises the toggle to DATA0
  assign tog_nxt = (tog_r ^ flip_mask) & ~(unstall_mask | tok_mask);
  assign setup_nxt = (setup_r & ~stall_mask) | stored_mask;
  assign ovr_nxt = (ovr_r & ~stat_mask) | (stored_mask & setup_r);
  assign intf_nxt = (intf_r & ~stat_mask) | eng_mask | stored_mask;
  // A filled double buffer hands the processor the other half
  assign cpu_side_select_nxt = (cpu_side_select_r ^ (cpu_mask & EP_DOUBLE)) | swap_mask;

  // Status byte of the selected endpoint
  logic [7:0] status_byte; // Bit 0 reads zero
  assign status_byte = {halt_r[ep_r], full1_r[ep_r], full0_r[ep_r], tog_r[ep_r],
                        ovr_r[ep_r], setup_r[ep_r], cpu_side_select_r[ep_r], STAT_RSVD};
  assign rdata_nxt = stat_rd ? {STAT_PAD, status_byte}
                   : ((cpu_rd || (dma_take && !BUS.wr)) ? a_rdata : rdata_r);

  // Soft reset request: one cycle, then the shared reset clears all
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= cmd_take && (code == CMD_RESET);
    end
  end

  // Processor side and DMA registers
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      phase_r <= PH_IDLE;
      ep_r <= '0;
      ptr_r <= '0;
      dma_on_r <= 1'b0;
      dma_ptr_r <= '0;
    end else begin
      phase_r <= phase_nxt;
      ep_r <= ep_nxt;
      ptr_r <= ptr_nxt;
      dma_on_r <= dma_on_nxt;
      dma_ptr_r <= dma_ptr_nxt;
    end
  end

  // Endpoint status registers
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      halt_r <= '0;
      full0_r <= '0;
      full1_r <= '0;
      tog_r <= '0;
      ovr_r <= '0;
      setup_r <= '0;
      cpu_side_select_r <= '0;
      intf_r <= '0;
    end else begin
      halt_r <= halt_nxt;
      full0_r <= full0_nxt;
      full1_r <= full1_nxt;
      tog_r <= tog_nxt;
      ovr_r <= ovr_nxt;
      setup_r <= setup_nxt;
      cpu_side_select_r <= cpu_side_select_nxt;
      intf_r <= intf_nxt;
    end
  end

  // Answer: every strobe is acknowledged one cycle later
  always_ff @(posedge SYS_CLK) begin
    if (rst_all) begin
      rdata_r <= '0;
      ack_r <= 1'b0;
      eop_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ack_r <= BUS.stb;
      eop_r <= dma_eop;
    end
  end

  assign BUS.rdata = rdata_r;
  assign BUS.ack = ack_r;
  assign BUS.eop = eop_r;
  assign FULL0 = full0_r;
  assign FULL1 = full1_r;
  assign HALTED = halt_r;
  assign INT_FLAGS = intf_r;
endmodule
`default_nettype wire

/* src/ep_cmd_host.sv */
/*
  Processor end of the endpoint buffer command port. Turns user requests
  into bus accesses, one outstanding at a time, and refuses illegal ones.
  Assumes the controller answers every strobe with ack one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module ep_cmd_host import epcmd_pkg::*; (
  input wire logic SYS_CLK, // System clock, 50 MHz
  input wire logic RESET, // Synchronous reset, active high
  cmd_port_if.host BUS, // Controller bus
  input wire logic U_REQ, // Request pulse
  input wire logic U_CMD, // Request is a command code
  input wire logic U_WR, // Request writes
  input wire logic U_DMA, // Request is a DMA access
  input wire logic [DATA_W-1:0] U_WDATA, // Code or data
  input wire logic [EP_W-1:0] U_DMA_EP, // DMA endpoint
  input wire logic U_EOT, // End DMA transfer pulse
  output logic U_READY, // Ready for a request
  output logic U_REFUSED, // Request refused pulse
  output logic [DATA_W-1:0] U_RDATA, // Read answer
  output logic U_RVALID, // Answer valid pulse
  output logic U_EOP // Last DMA word pulse
);
  phase_t mode_r, mode_nxt; // Direction opened by last command
  logic [PTR_W-1:0] cnt_r, cnt_nxt; // Words moved since command
  logic busy_r; // Access outstanding
  logic busy_nxt; // Outstanding after this edge
  logic ready_r; // Registered copy of not busy, so the output comes from a flop
  logic stb_r, sel_r, wr_r, dma_r, eot_r; // Bus drive
  logic [DATA_W-1:0] wd_r; // Bus data
  logic [EP_W-1:0] dep_r; // DMA endpoint
  logic [DATA_W-1:0] rd_r; // Answer data
  logic rv_r, eop_r, ref_r; // Answer pulses

  // Decode of the request
  logic [3:0] grp, cep; // Code group and endpoint
  logic bad_dir, over, ok, take; // Checks
  assign grp = U_WDATA[7:4];
  assign cep = U_WDATA[3:0];
  // Data against the opened direction is never sent
  assign bad_dir = (mode_r == PH_WRITE && !U_WR) || (mode_r == PH_READ && U_WR)
                 || (mode_r == PH_STATUS && U_WR) || mode_r == PH_IDLE;
  assign over = (mode_r != PH_STATUS) && (cnt_r >= XFER_WORDS);
  assign ok = U_CMD || U_DMA || !(bad_dir || over);
  assign take = U_REQ && !busy_r;
  assign mode_nxt = (take && U_CMD) ?
                    (((grp == GRP_WR) && (cep != WR_HOLE)) ? PH_WRITE
                     : ((grp == GRP_RD) && (cep != RD_HOLE)) ? PH_READ
                     : (grp == GRP_STAT) ? PH_STATUS : PH_IDLE) : mode_r;
  assign cnt_nxt = (take && U_CMD) ? LEN_WORD
                 : (take && ok && !U_DMA) ? PTR_W'(cnt_r + PTR_STEP) : cnt_r;
  // Busy from an accepted request until its ack
  assign busy_nxt = busy_r ? !BUS.ack : (take && ok);

  // Bus drive and bookkeeping
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      mode_r <= PH_IDLE;
      cnt_r <= '0;
      busy_r <= 1'b0;
      ready_r <= 1'b1;
      stb_r <= 1'b0;
      sel_r <= 1'b0;
      wr_r <= 1'b0;
      dma_r <= 1'b0;
      eot_r <= 1'b0;
      wd_r <= '0;
      dep_r <= '0;
      ref_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      stb_r <= take && ok;
      busy_r <= busy_nxt;
      ready_r <= !busy_nxt;
      ref_r <= take && !ok;
      eot_r <= U_EOT;
      dep_r <= U_DMA_EP;
      if (take) begin
        sel_r <= U_CMD;
        wr_r <= U_WR || U_CMD;
        dma_r <= U_DMA && !U_CMD;
        // Upper byte is cleared under a command code
        wd_r <= U_CMD ? {STAT_PAD, U_WDATA[7:0]} : U_WDATA;
      end
    end
  end

  // Answers back to the user side
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rd_r <= '0;
      rv_r <= 1'b0;
      eop_r <= 1'b0;
    end else begin
      rv_r <= BUS.ack && !wr_r;
      eop_r <= BUS.ack && BUS.eop;
      if (BUS.ack && !wr_r) begin
        rd_r <= BUS.rdata;
      end
    end
  end

  assign BUS.stb = stb_r;
  assign BUS.cmd_data_select = sel_r;
  assign BUS.wr = wr_r;
  assign BUS.dma = dma_r;
  assign BUS.wdata = wd_r;
  assign BUS.dma_ep = dep_r;
  assign BUS.transfer_end_signal = eot_r;
  assign U_READY = ready_r;
  assign U_REFUSED = ref_r;
  assign U_RDATA = rd_r;
  assign U_RVALID = rv_r;
  assign U_EOP = eop_r;
endmodule
`default_nettype wire

/* testbench/cmd_port_checker.sv */
/* Bus checker for the command port.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module cmd_port_checker (
  input wire logic SYS_CLK, // Clock
  input wire logic RESET, // Reset
  input wire logic stb, // Strobe
  input wire logic cmd_data_select, // Code or data
  input wire logic wr, // Write
  input wire logic dma, // DMA access
  input wire logic [15:0] wdata, // Toward controller
  input wire logic [15:0] rdata, // Answer
  input wire logic ack, // Answer mark
  input wire logic eop // Last DMA word
);
  logic stat_r; // Status code open
  wire f6 = stb && cmd_data_select && !dma && wdata[7:0] == 8'hf6; // Reset code
  // Each strobe decides whether the next data read is a status byte
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      stat_r <= 1'b0;
    end else if (stb) begin
      stat_r <= cmd_data_select && !dma && wdata[7:4] == 4'h5;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  ack_follows_a: assert property (stb |=> ack) else $error("no ack");
  ack_cause_a: assert property (ack |-> $past(stb)) else $error("stray ack");
  strobe_gap_a: assert property (stb |=> !stb) else $error("strobe too close");
  eop_ack_a: assert property (eop |-> ack) else $error("eop alone");
  eop_dma_a: assert property (eop |-> $past(stb && dma && !wr)) else $error("eop off DMA read");
  reset_code_a: assert property (f6 |=> ack ##1 (!ack && !eop && rdata == 16'h0000)) else $error("reset code");
  status_byte_a: assert property (stb && !cmd_data_select && !wr && !dma && stat_r |=> !rdata[0] && rdata[15:8] == 8'h00)
    else $error("status byte");
  rdata_hold_a: assert property ($changed(rdata) |-> $past(stb && !wr) || $past(f6, 2)) else $error("rdata moved");
endmodule
`default_nettype wire

/* testbench/test_endpoint_buffer_command_port.sv */
/* Bench: host end and controller end joined by the bus interface.
   Assumes the package, interface and both ends are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_endpoint_buffer_command_port import epcmd_pkg::*;;
  logic SYS_CLK = 1'b0; // 20 ns period
  logic RESET = 1'b1; // Held 8 cycles
  logic u_req = 0, u_cmd = 0, u_wr = 0, u_dma = 0, u_eot = 0; // User request
  logic [15:0] u_wdata = '0; // User code or data
  logic [3:0] u_ep = '0, eng_ep = '0; // DMA and engine endpoint
  logic eng_we = 0, done = 0, tok = 0, stored = 0, tog = 0; // Engine pulses
  logic [15:0] ep_in = 16'h0004; // Only endpoint 2 is IN
  wire logic u_ready, u_ref, u_rv, u_eop; // User answers
  wire logic [15:0] u_rdata, full0, full1, halted, int_flags, eng_rdata; // Flags
  logic [16:0] expq[$]; // Expected {eop, data}
  logic [16:0] e_n; // Oldest note
  logic [15:0] wd[16][3]; // Words written per endpoint
  int n_errors = 0, checks = 0, seed = 50, cyc = 0; // Counters
  always #10 SYS_CLK = ~SYS_CLK;
  cmd_port_if cmd_port_if_inst ();
  ep_cmd_device ep_cmd_device_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .BUS(cmd_port_if_inst.dev),
    .EP_IS_IN(ep_in), .EP_DOUBLE(16'h0000), .ENG_WE(eng_we), .ENG_ADDR(10'h000), .ENG_WDATA(16'h0002),
    .ENG_RDATA(eng_rdata), .ENG_EP(eng_ep), .ENG_BUF(1'b0), .ENG_PKT_DONE(done), .ENG_SETUP_TOKEN(tok),
    .ENG_SETUP_STORED(stored), .ENG_TOGGLE(tog), .FULL0(full0), .FULL1(full1), .HALTED(halted),
    .INT_FLAGS(int_flags));
  ep_cmd_host ep_cmd_host_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .BUS(cmd_port_if_inst.host),
    .U_REQ(u_req), .U_CMD(u_cmd), .U_WR(u_wr), .U_DMA(u_dma), .U_WDATA(u_wdata), .U_DMA_EP(u_ep),
    .U_EOT(u_eot), .U_READY(u_ready), .U_REFUSED(u_ref), .U_RDATA(u_rdata), .U_RVALID(u_rv), .U_EOP(u_eop));
  cmd_port_checker cmd_port_checker_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .stb(cmd_port_if_inst.stb),
    .cmd_data_select(cmd_port_if_inst.cmd_data_select), .wr(cmd_port_if_inst.wr), .dma(cmd_port_if_inst.dma),
    .wdata(cmd_port_if_inst.wdata), .rdata(cmd_port_if_inst.rdata), .ack(cmd_port_if_inst.ack),
    .eop(cmd_port_if_inst.eop));
  task automatic close_out();
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [16:0] e, input logic [16:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One user request; a refusal shows one cycle later
  task automatic req(input logic c, input logic w, input logic d, input logic [15:0] v, input logic rf);
    int k;
    k = 0;
    while (u_ready !== 1'b1 && k < 50) begin
      @(negedge SYS_CLK);
      k++;
    end
    u_req = 1;
    u_cmd = c;
    u_wr = w;
    u_dma = d;
    u_wdata = v;
    @(negedge SYS_CLK);
    u_req = 0;
    cmp("refused", {16'h0000, rf}, {16'h0000, u_ref});
  endtask
  task automatic get(input logic d, input logic [16:0] e);
    expq.push_back(e);
    req(0, 0, d, 16'h0000, 0);
  endtask
  task automatic stat(input logic [7:0] code, input logic [7:0] s);
    req(1, 1, 0, {8'h00, code}, 0);
    get(0, {9'h000, s});
    repeat (4) @(negedge SYS_CLK);
  endtask
  // Engine pulses {write, toggle, stored, token, done}, then one idle cycle
  task automatic eng(input logic [4:0] m, input logic [3:0] ep);
    eng_ep = ep;
    {eng_we, tog, stored, tok, done} = m;
    @(negedge SYS_CLK);
    {eng_we, tog, stored, tok, done} = 5'h00;
    @(negedge SYS_CLK);
  endtask
  // Answers are matched in order against the notes
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
    if (u_rv === 1'b1) begin
      e_n = (expq.size() > 0) ? expq.pop_front() : 17'h1ffff;
      cmp("answer", e_n, {u_eop, u_rdata});
    end
  end
  initial begin
    repeat (8) @(negedge SYS_CLK);
    RESET = 0;
    eng(5'h10, 4'h0);
    wd[0][0] = 16'h0002;
    for (int e = 1; e < 16; e++) begin
      wd[e][0] = 16'h0004;
      wd[e][1] = 16'($random(seed));
      wd[e][2] = 16'($random(seed));
      req(1, 1, 0, {12'h000, e[3:0]}, 0);
      for (int i = 0; i < 3; i++) req(0, 1, 0, wd[e][i], 0);
    end
    for (int e = 0; e < 16; e++) begin
      if (e != 1) begin
        req(1, 1, 0, {12'ha01, e[3:0]}, 0);
        get(0, {1'b0, wd[e][0]});
        for (int i = 1; i < 3 && e != 0; i++) get(0, {1'b0, wd[e][i]});
      end
    end
    req(1, 1, 0, 16'h0011, 0);
    req(0, 0, 0, 16'h0000, 1);
    u_ep = 4'h5;
    get(1, {1'b0, wd[5][1]});
    get(1, {1'b1, wd[5][2]});
    req(1, 1, 0, 16'h0002, 0);
    for (int i = 0; i < 18; i++) req(0, 1, 0, i[15:0], i == 17);
    repeat (4) @(negedge SYS_CLK);
    cmp("full0", 17'h00004, {1'b0, full0});
    cmp("eng_rdata", 17'h00002, {1'b0, eng_rdata});
    stat(8'h52, 8'h20);
    eng(5'h01, 4'h2);
    cmp("int", 17'h00004, {1'b0, int_flags});
    stat(8'h52, 8'h00);
    cmp("int", 17'h00000, {1'b0, int_flags});
    req(1, 1, 0, 16'h0043, 0);
    eng(5'h08, 4'h3);
    stat(8'h53, 8'h90);
    eng(5'h02, 4'h3);
    cmp("halted", 17'h00000, {1'b0, halted});
    eng(5'h04, 4'h3);
    eng(5'h04, 4'h3);
    stat(8'h53, 8'h0c);
    // Overrun seen: no stall, wait for the next set-up token instead
    eng(5'h02, 4'h3);
    stat(8'h53, 8'h04);
    req(1, 1, 0, 16'h0044, 0);
    repeat (4) @(negedge SYS_CLK);
    cmp("halted", 17'h00010, {1'b0, halted});
    // One DMA word into the IN buffer, then an external end hands it over
    u_ep = 4'h2;
    req(0, 1, 1, 16'h1234, 0);
    u_eot = 1;
    @(negedge SYS_CLK);
    u_eot = 0;
    repeat (4) @(negedge SYS_CLK);
    cmp("eot_full0", 17'h00004, {1'b0, full0});
    req(1, 1, 0, 16'h00f6, 0);
    repeat (4) @(negedge SYS_CLK);
    cmp("flags", 17'h00000, {1'b0, halted | full0 | full1 | int_flags});
    stat(8'h53, 8'h00);
    cmp("pending", 17'h00000, 17'(expq.size()));
    close_out();
  end
endmodule
`default_nettype wire
